/* File: rtl/dcs_regs.vh */
// Constants for the dynamic clock switch block
`ifndef DCS_REGS_VH
`define DCS_REGS_VH
// Command codes
`define DCS_CMD_DISABLE   8'h01
`define DCS_CMD_ENABLE    8'h02
`define DCS_CMD_REQUEST   8'h03
`define DCS_CMD_SWITCH    8'h04
`define DCS_CMD_RECOVER   8'h05
`define DCS_CMD_WDARL     8'h06
// Command register bit positions
`define DCS_CCE_BIT       7
`define DCS_RDY_BIT       6
// Clock selection register layout
`define DCS_SEL_LSB       0
`define DCS_SEL_MSB       3
`define DCS_SUT_LSB       4
`define DCS_SUT_MSB       5
`define DCS_CLOCK_OUTPUT_BIT_BIT      6
// Timer request synchroniser bit positions
`define DCS_TREQ_LF       0
`define DCS_TREQ_EXT      1
// Source select codes (mapped to source ids by the decoder)
`define DCS_SRC_RC        4'h2
`define DCS_SRC_WD        4'h3
`define DCS_SRC_EXT       4'h0
`define DCS_SRC_LF        4'h6
`define DCS_SRC_HF        4'h8
`define DCS_SRC_HF_MASK   4'h8
`define DCS_SRC_LF_MASK   4'hE
// Source identifiers for the enable vector
`define DCS_ID_RC         3'h0
`define DCS_ID_WD         3'h1
`define DCS_ID_EXT        3'h2
`define DCS_ID_LF         3'h3
`define DCS_ID_HF         3'h4
`define DCS_ID_NONE       3'h7
// Start-up codes
`define DCS_SUT_00        2'h0
`define DCS_SUT_01        2'h1
`define DCS_SUT_10        2'h2
`define DCS_SUT_11        2'h3
// Start-up cycle figures
`define DCS_LF_SHORT_CK   16'h0400
`define DCS_LF_LONG_CK    16'h8000
`define DCS_EXT_WAKE_CK   16'h0006
`define DCS_EXT_RST_CK    16'h000E
// Reset delay times in microseconds, and the bus clock in MHz
`define DCS_T41_US        4100
`define DCS_T4_US         4000
`define DCS_T65_US        65000
`define DCS_CLK_MHZ       50
`endif

/* File: rtl/dcs_startup_counter.v */
// Start-up cycle counter driven by the selected source's clock
`timescale 1ns/1ps
`default_nettype none
module dcs_startup_counter #(
  parameter CW = 16
) (
  // Clock and reset
  input  wire          i_mclk,
  input  wire          i_sys_rst,
  // Control
  input  wire          i_start,
  input  wire [CW-1:0] i_limit,
  input  wire          i_src_tick,
  // Status
  output reg           o_ready_ff
);
  reg [CW-1:0] cnt_ff;
  reg          run_ff;

  // Count source edges until the limit; ready holds until restart
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_ff     <= {CW{1'b0}};
      run_ff     <= 1'b0;
      o_ready_ff <= 1'b0;
    end else if (i_start) begin
      cnt_ff     <= {CW{1'b0}};
      run_ff     <= 1'b1;
      o_ready_ff <= 1'b0;
    end else if (run_ff && i_src_tick) begin
      if (cnt_ff + 1'b1 >= i_limit) begin
        run_ff     <= 1'b0;
        o_ready_ff <= 1'b1;
      end
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/dcs_clock_switch.v */
// Dynamic clock switch: command decoder, source enables, clock handover
`timescale 1ns/1ps
`default_nettype none
`include "dcs_regs.vh"
module dcs_clock_switch #(
  parameter T65_CYC  = (`DCS_T65_US * `DCS_CLK_MHZ),
  parameter T41_CYC  = (`DCS_T41_US * `DCS_CLK_MHZ),
  parameter T4_CYC   = (`DCS_T4_US * `DCS_CLK_MHZ)
) (
  // Clock and reset
  input  wire       i_mclk,
  input  wire       i_sys_rst,
  // Fuse straps
  input  wire [3:0] i_fuse_source_select,
  input  wire [1:0] i_fuse_startup,
  input  wire       i_fuse_clock_output,
  input  wire       i_reset_pin_disable_fuse,
  // Software writes
  input  wire       i_sel_wr,
  input  wire [7:0] i_sel_wdata,
  input  wire       i_cmd_wr,
  input  wire [7:0] i_cmd_wdata,
  // Source clock activity, asynchronous to i_mclk
  input  wire [4:0] i_src_clk,
  // Asynchronous timer requests
  input  wire       i_timer_lf_req,
  input  wire       i_timer_ext_req,
  // Prescaled system clock enable tick
  input  wire       i_sysclk_div,
  // Register readback
  output wire [7:0] o_clock_selection_register,
  output wire [7:0] o_clock_command_register,
  // Source enables and selection
  output reg  [4:0] o_src_en_ff,
  output reg  [2:0] o_sys_src_ff,
  output reg        o_wd_autoreload_ff,
  output wire       o_reset_delay_busy,
  // Clock output pin
  output reg        o_clock_out_pin_ff,
  output wire       o_clock_out_pin_oe
);
  reg [3:0]  sel_ff;
  reg [1:0]  sut_ff;
  reg        clock_output_bit_ff;
  reg        cce_ff;
  reg        fuse_load_ff;
  reg [4:0]  sync1_ff;
  reg [4:0]  sync2_ff;
  reg [4:0]  sync3_ff;
  reg [1:0]  treq1_ff;
  reg [1:0]  treq2_ff;
  reg        cnt_start_ff;
  reg [2:0]  sw_target_ff;
  reg        sw_pend_ff;
  reg [1:0]  sw_state_ff;
  reg [22:0] rdelay_ff;
  reg [22:0] nxt_rdelay;
  reg [2:0]  sel_id;
  reg [15:0] limit;
  wire       ready;
  wire [4:0] src_tick;
  wire       cmd_ok;
  wire       xtal_used;
  wire       fuse_lf;

  localparam SW_IDLE = 2'b00;
  localparam SW_OLD  = 2'b01;
  localparam SW_NEW  = 2'b10;

  // ---------------------------------------------------------------
  // Source decode
  // ---------------------------------------------------------------
  // Map select code to source id
  always @* begin
    sel_id = `DCS_ID_NONE;
    if (sel_ff == `DCS_SRC_RC)
      sel_id = `DCS_ID_RC;
    else if (sel_ff == `DCS_SRC_WD)
      sel_id = `DCS_ID_WD;
    else if (sel_ff == `DCS_SRC_EXT)
      sel_id = `DCS_ID_EXT;
    else if ((sel_ff & `DCS_SRC_LF_MASK) == `DCS_SRC_LF)
      sel_id = `DCS_ID_LF;
    else if ((sel_ff & `DCS_SRC_HF_MASK) == `DCS_SRC_HF)
      sel_id = `DCS_ID_HF;
  end

  // Cycle limit from start-up field
  always @* begin
    limit = `DCS_EXT_WAKE_CK;
    if (sel_id == `DCS_ID_LF) begin
      if (sut_ff == `DCS_SUT_10)
        limit = `DCS_LF_LONG_CK;
      else
        limit = `DCS_LF_SHORT_CK;
    end else begin
      limit = `DCS_EXT_WAKE_CK;
    end
  end

  // ---------------------------------------------------------------
  // Source clock synchronisers
  // ---------------------------------------------------------------
  // de-glitch sync; timer requests come from the timer's own clock
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      sync3_ff <= 5'h00;
      treq1_ff <= 2'h0;
      treq2_ff <= 2'h0;
    end else begin
      sync1_ff <= i_src_clk;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      treq1_ff <= {i_timer_ext_req, i_timer_lf_req};
      treq2_ff <= treq1_ff;
    end
  end
  assign src_tick = sync2_ff & ~sync3_ff;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  // guard window
  assign cmd_ok = i_cmd_wr && cce_ff;
  assign xtal_used = o_src_en_ff[`DCS_ID_LF] | o_src_en_ff[`DCS_ID_HF];
  assign fuse_lf = (i_fuse_source_select & `DCS_SRC_LF_MASK) == `DCS_SRC_LF;

  // Selection register, guard bit, enables and modes
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sel_ff             <= 4'h0;
      sut_ff             <= 2'h0;
      clock_output_bit_ff            <= 1'b0;
      fuse_load_ff       <= 1'b1;
      cce_ff             <= 1'b0;
      o_src_en_ff        <= 5'h01;
      o_wd_autoreload_ff <= 1'b0;
      cnt_start_ff       <= 1'b0;
      sw_pend_ff         <= 1'b0;
      sw_target_ff       <= `DCS_ID_RC;
    end else begin
      cnt_start_ff <= 1'b0;
      sw_pend_ff   <= 1'b0;
      if (fuse_load_ff) begin
        fuse_load_ff <= 1'b0;
        sel_ff       <= i_fuse_source_select;
        sut_ff       <= i_fuse_startup;
        clock_output_bit_ff      <= ~i_fuse_clock_output;
      end else if (i_sel_wr) begin
        sel_ff  <= i_sel_wdata[`DCS_SEL_MSB:`DCS_SEL_LSB];
        sut_ff  <= i_sel_wdata[`DCS_SUT_MSB:`DCS_SUT_LSB];
        clock_output_bit_ff <= i_sel_wdata[`DCS_CLOCK_OUTPUT_BIT_BIT];
      end
      if (i_cmd_wr)
        cce_ff <= i_cmd_wdata[`DCS_CCE_BIT] & ~cce_ff;
      else
        cce_ff <= 1'b0;
      if (cmd_ok && !fuse_load_ff && sel_id != `DCS_ID_NONE) begin
        case (i_cmd_wdata)
          `DCS_CMD_DISABLE: begin
            if (sel_id != o_sys_src_ff)
              o_src_en_ff[sel_id] <= 1'b0;
          end
          `DCS_CMD_ENABLE: begin
            o_src_en_ff[sel_id] <= 1'b1;
            if (sel_id == `DCS_ID_EXT || sel_id == `DCS_ID_LF ||
                sel_id == `DCS_ID_HF) begin
              o_src_en_ff[`DCS_ID_EXT] <= (sel_id == `DCS_ID_EXT);
              o_src_en_ff[`DCS_ID_LF]  <= (sel_id == `DCS_ID_LF);
              o_src_en_ff[`DCS_ID_HF]  <= (sel_id == `DCS_ID_HF);
            end
            cnt_start_ff <= 1'b1;
          end
          `DCS_CMD_REQUEST: begin
            cnt_start_ff <= 1'b1;
          end
          `DCS_CMD_SWITCH: begin
            sw_pend_ff   <= 1'b1;
            sw_target_ff <= sel_id;
          end
          `DCS_CMD_WDARL: begin
            o_wd_autoreload_ff <= 1'b1;
          end
          default: begin
            cnt_start_ff <= 1'b0;
          end
        endcase
      end
      if (cmd_ok && i_cmd_wdata == `DCS_CMD_RECOVER) begin
        case (o_sys_src_ff)
          `DCS_ID_RC:  sel_ff <= `DCS_SRC_RC;
          `DCS_ID_WD:  sel_ff <= `DCS_SRC_WD;
          `DCS_ID_EXT: sel_ff <= `DCS_SRC_EXT;
          `DCS_ID_LF:  sel_ff <= `DCS_SRC_LF;
          default:     sel_ff <= `DCS_SRC_HF;
        endcase
      end
      // timer shares oscillators, one external at a time
      if (treq2_ff[`DCS_TREQ_LF] && !o_src_en_ff[`DCS_ID_HF] &&
          !o_src_en_ff[`DCS_ID_EXT])
        o_src_en_ff[`DCS_ID_LF] <= 1'b1;
      else if (treq2_ff[`DCS_TREQ_EXT] && !xtal_used)
        o_src_en_ff[`DCS_ID_EXT] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Availability counter
  // ---------------------------------------------------------------
  // ready flag
  dcs_startup_counter #(
    .CW (16)
  ) u_cnt (
    .i_mclk     (i_mclk),
    .i_sys_rst  (i_sys_rst),
    .i_start    (cnt_start_ff),
    .i_limit    (limit),
    .i_src_tick (src_tick[sel_id == `DCS_ID_NONE ? 0 : sel_id]),
    .o_ready_ff (ready)
  );

  // ---------------------------------------------------------------
  // Glitch-free handover
  // ---------------------------------------------------------------
  // wait for old then new clock edges
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sw_state_ff  <= SW_IDLE;
      o_sys_src_ff <= `DCS_ID_RC;
    end else begin
      case (sw_state_ff)
        SW_IDLE:
          if (sw_pend_ff && o_src_en_ff[sw_target_ff])
            sw_state_ff <= SW_OLD;
        SW_OLD:
          if (src_tick[o_sys_src_ff])
            sw_state_ff <= SW_NEW;
        SW_NEW:
          if (src_tick[sw_target_ff]) begin
            o_sys_src_ff <= sw_target_ff;
            sw_state_ff  <= SW_IDLE;
          end
        default:
          sw_state_ff <= SW_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Reset delay and clock output
  // ---------------------------------------------------------------
  // reset delay; the 14-cycle base is for non-LF sources only
  always @* begin
    nxt_rdelay = 23'h0;
    case (i_fuse_startup)
      `DCS_SUT_00: nxt_rdelay = fuse_lf ? T41_CYC[22:0] :
                     ({7'h00, `DCS_EXT_RST_CK} +
                      (i_reset_pin_disable_fuse ? T4_CYC[22:0] : 23'h0));
      `DCS_SUT_01: nxt_rdelay = fuse_lf ? T65_CYC[22:0] :
                     ({7'h00, `DCS_EXT_RST_CK} + T41_CYC[22:0]);
      `DCS_SUT_10: nxt_rdelay = fuse_lf ? T65_CYC[22:0] :
                     ({7'h00, `DCS_EXT_RST_CK} + T65_CYC[22:0]);
      default:     nxt_rdelay = 23'h0;
    endcase
  end

  // Reset delay counts down after fuse load
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      rdelay_ff <= 23'h0;
    else if (fuse_load_ff)
      rdelay_ff <= nxt_rdelay;
    else if (rdelay_ff != 23'h0)
      rdelay_ff <= rdelay_ff - 23'h1;
  end
  assign o_reset_delay_busy = fuse_load_ff | (rdelay_ff != 23'h0);

  // toggle on prescaled tick, off in reset
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      o_clock_out_pin_ff <= 1'b0;
    else if (i_sysclk_div)
      o_clock_out_pin_ff <= ~o_clock_out_pin_ff;
  end
  assign o_clock_out_pin_oe = ~i_sys_rst & ~xtal_used & clock_output_bit_ff &
                              ~o_reset_delay_busy;

  // Register readback
  assign o_clock_selection_register = {1'b0, clock_output_bit_ff, sut_ff, sel_ff};
  assign o_clock_command_register   = {cce_ff, ready, 6'h00};
endmodule
`default_nettype wire

/* File: tb/dcs_clock_switch_assertions.sv */
// Concurrent checks on the dynamic clock switch ports
`timescale 1ns/1ps
`default_nettype none
module dcs_clock_switch_assertions (
  // Clock and reset
  input wire logic       i_mclk,
  input wire logic       i_sys_rst,
  // Software and prescaler inputs
  input wire logic       i_cmd_wr,
  input wire logic [7:0] i_cmd_wdata,
  input wire logic       i_sysclk_div,
  // Observed outputs
  input wire logic [7:0] o_clock_command_register,
  input wire logic [4:0] o_src_en_ff,
  input wire logic [2:0] o_sys_src_ff,
  input wire logic       o_wd_autoreload_ff,
  input wire logic       o_clock_out_pin_ff,
  input wire logic       o_clock_out_pin_oe
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // ---------------------------------------------------------------
  // Command steps
  // ---------------------------------------------------------------
  // Change-enable write from an idle guard, then at once the command value
  sequence guarded_cmd(logic [7:0] code);
    i_cmd_wr && i_cmd_wdata[7] && !o_clock_command_register[7] ##1
    i_cmd_wr && (i_cmd_wdata == code);
  endsequence
  // Ready must drop two edges after a counting command
  property count_restart(logic [7:0] code);
    guarded_cmd(code) |=> ##1 !o_clock_command_register[6];
  endproperty
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  wdarl_set_a: assert property (guarded_cmd(8'h06) |=> o_wd_autoreload_ff)
    else $error("auto reload not set by command");
  wdarl_hold_a: assert property (o_wd_autoreload_ff |=> o_wd_autoreload_ff)
    else $error("auto reload cleared without reset");
  unguarded_refused_a: assert property (i_cmd_wr && i_cmd_wdata == 8'h06 &&
    !($past(i_cmd_wr) && $past(i_cmd_wdata[7])) && !o_wd_autoreload_ff |=> !o_wd_autoreload_ff)
    else $error("unguarded command took effect");
  enable_count_a: assert property (count_restart(8'h02))
    else $error("ready not cleared after enable");
  request_count_a: assert property (count_restart(8'h03))
    else $error("ready not cleared after request");
  ready_fall_a: assert property ($fell(o_clock_command_register[6]) |->
    $past(i_cmd_wr, 2) && ($past(i_cmd_wdata, 2) == 8'h02 || $past(i_cmd_wdata, 2) == 8'h03))
    else $error("ready fell without a count command");
  sys_enabled_a: assert property (o_sys_src_ff <= 3'h4 && o_src_en_ff[o_sys_src_ff])
    else $error("system source not enabled");
  out_reset_a: assert property (disable iff (1'b0) i_sys_rst |-> !o_clock_out_pin_oe)
    else $error("clock out driven in reset");
  out_tick_a: assert property ($changed(o_clock_out_pin_ff) |-> $past(i_sysclk_div))
    else $error("clock out moved without prescaled tick");
endmodule
`default_nettype wire

/* File: tb/test_dcs_clock_switch.sv */
// Self-checking bench for the dynamic clock switch
`timescale 1ns/1ps
`default_nettype none
module test_dcs_clock_switch;
  logic       i_mclk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       i_sel_wr = 1'b0, i_cmd_wr = 1'b0, i_sysclk_div = 1'b0;
  logic [7:0] i_sel_wdata = 8'h00, i_cmd_wdata = 8'h00;
  logic [7:0] src_cnt = 8'h00;
  logic [7:0] sel_reg, cmd_reg;
  logic [4:0] en;
  logic [2:0] sys;
  logic       wdarl, busy, pin, oe, p;
  logic [3:0] fuse_sel = 4'h2;
  logic [1:0] fuse_sut = 2'h0;
  logic       fuse_cko = 1'b0, fuse_rpd = 1'b0, tmr_lf = 1'b0, tmr_ext = 1'b0;
  int         num_errors = 0, n_tests = 0, busy_cyc = 0;
  // ---------------------------------------------------------------
  // Clock, source clocks and design
  // ---------------------------------------------------------------
  always #10 i_mclk = ~i_mclk;
  // Source clocks at a quarter of the bus rate keep counts short
  always @(posedge i_mclk) src_cnt <= src_cnt + 8'h01;
  dcs_clock_switch #(.T65_CYC(20), .T41_CYC(20), .T4_CYC(20)) dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_fuse_source_select(fuse_sel), .i_fuse_startup(fuse_sut),
    .i_fuse_clock_output(fuse_cko), .i_reset_pin_disable_fuse(fuse_rpd),
    .i_sel_wr(i_sel_wr), .i_sel_wdata(i_sel_wdata),
    .i_cmd_wr(i_cmd_wr), .i_cmd_wdata(i_cmd_wdata),
    .i_src_clk({5{src_cnt[1]}}), .i_timer_lf_req(tmr_lf),
    .i_timer_ext_req(tmr_ext), .i_sysclk_div(i_sysclk_div),
    .o_clock_selection_register(sel_reg), .o_clock_command_register(cmd_reg),
    .o_src_en_ff(en), .o_sys_src_ff(sys), .o_wd_autoreload_ff(wdarl),
    .o_reset_delay_busy(busy), .o_clock_out_pin_ff(pin),
    .o_clock_out_pin_oe(oe));
  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_sel(input logic [7:0] d);
    @(posedge i_mclk) begin i_sel_wr <= 1'b1; i_sel_wdata <= d; end
    @(posedge i_mclk) i_sel_wr <= 1'b0;
    #1;
  endtask
  // Guarded command, or a bare write when guard is 0
  task automatic cmd(input logic [7:0] code, input logic guard);
    if (guard) @(posedge i_mclk) begin i_cmd_wr <= 1'b1; i_cmd_wdata <= 8'h80; end
    @(posedge i_mclk) begin i_cmd_wr <= 1'b1; i_cmd_wdata <= code; end
    @(posedge i_mclk) i_cmd_wr <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  task automatic wait_rdy(input int lim);
    for (int i = 0; i < lim && cmd_reg[6] !== 1'b1; i++) @(posedge i_mclk);
    #1;
  endtask
  // One-cycle timer request; three edges cover the two-stage sync
  task automatic tmr_pulse(input logic lf, input logic ext);
    @(posedge i_mclk) begin tmr_lf <= lf; tmr_ext <= ext; end
    @(posedge i_mclk) begin tmr_lf <= 1'b0; tmr_ext <= 1'b0; end
    repeat (3) @(posedge i_mclk);
    #1;
  endtask
  // Reset for two edges with new straps {rpd, cko, sut, sel}; count busy
  task automatic pulse_rst(input logic [7:0] straps, output int n);
    @(posedge i_mclk) begin
      i_sys_rst <= 1'b1;
      {fuse_rpd, fuse_cko, fuse_sut, fuse_sel} <= straps;
    end
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 300) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
  endtask
  task automatic finish_test;
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard at three times the expected ten thousand cycles
  initial begin
    #600000;
    num_errors++;
    finish_test;
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge i_mclk);
    #1;
    chk(sel_reg, 8'h42);
    chk({3'h0, en}, 8'h01);
    chk({7'h0, oe}, 8'h01);
    p = pin;
    @(posedge i_mclk) i_sysclk_div <= 1'b1;
    @(posedge i_mclk) i_sysclk_div <= 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk({7'h0, pin}, {7'h0, ~p});
    wr_sel(8'h02);
    chk({7'h0, oe}, 8'h00);
    // Watchdog oscillator, clock-out switched back on
    wr_sel(8'h43);
    cmd(8'h02, 1'b0);
    chk({3'h0, en}, 8'h01);
    @(posedge i_mclk) begin i_cmd_wr <= 1'b1; i_cmd_wdata <= 8'h80; end
    @(posedge i_mclk) i_cmd_wr <= 1'b0;
    cmd(8'h02, 1'b0);
    chk({3'h0, en}, 8'h01);
    cmd(8'h02, 1'b1);
    chk({3'h0, en}, 8'h03);
    chk({7'h0, cmd_reg[6]}, 8'h00);
    wait_rdy(300);
    chk({7'h0, cmd_reg[6]}, 8'h01);
    wr_sel(8'h42);
    cmd(8'h01, 1'b1);
    chk({3'h0, en}, 8'h03);
    // Hand over to the watchdog oscillator, then read it back
    wr_sel(8'h43);
    cmd(8'h04, 1'b1);
    for (int i = 0; i < 300 && sys !== 3'h1; i++) @(posedge i_mclk);
    #1;
    chk({5'h0, sys}, 8'h01);
    wr_sel(8'h40);
    cmd(8'h05, 1'b1);
    chk(sel_reg, 8'h43);
    wr_sel(8'h42);
    cmd(8'h01, 1'b1);
    chk({3'h0, en}, 8'h02);
    // Timer borrows the external input, then is refused the crystal
    tmr_pulse(1'b0, 1'b1);
    chk({3'h0, en}, 8'h06);
    tmr_pulse(1'b1, 1'b0);
    chk({3'h0, en}, 8'h06);
    // Low-frequency crystal, short start-up of 1024 source cycles
    wr_sel(8'h46);
    cmd(8'h02, 1'b1);
    chk({3'h0, en}, 8'h0A);
    chk({7'h0, oe}, 8'h00);
    repeat (3000) @(posedge i_mclk);
    #1;
    chk({7'h0, cmd_reg[6]}, 8'h00);
    wait_rdy(2000);
    chk({7'h0, cmd_reg[6]}, 8'h01);
    cmd(8'h03, 1'b1);
    chk({7'h0, cmd_reg[6]}, 8'h00);
    wait_rdy(5200);
    chk({7'h0, cmd_reg[6]}, 8'h01);
    cmd(8'h06, 1'b0);
    chk({7'h0, wdarl}, 8'h00);
    cmd(8'h06, 1'b1);
    chk({7'h0, wdarl}, 8'h01);
    chk({3'h0, en}, 8'h0A);
    cmd(8'h05, 1'b1);
    chk({7'h0, wdarl}, 8'h01);
    // Mid-run reset: LF straps, long start-up, clock-out fuse unprogrammed
    pulse_rst(8'h66, busy_cyc);
    chk(busy_cyc[7:0], 8'h15);
    chk(sel_reg, 8'h26);
    chk({7'h0, wdarl}, 8'h00);
    chk({5'h0, sys}, 8'h00);
    tmr_pulse(1'b1, 1'b0);
    chk({3'h0, en}, 8'h09);
    tmr_pulse(1'b0, 1'b1);
    chk({3'h0, en}, 8'h09);
    // External clock straps, then again with the reset pin disabled
    pulse_rst(8'h00, busy_cyc);
    chk(busy_cyc[7:0], 8'h0F);
    chk({7'h0, oe}, 8'h01);
    pulse_rst(8'h80, busy_cyc);
    chk(busy_cyc[7:0], 8'h23);
    finish_test;
  end
endmodule
bind dcs_clock_switch dcs_clock_switch_assertions u_chk (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cmd_wr(i_cmd_wr),
  .i_cmd_wdata(i_cmd_wdata), .i_sysclk_div(i_sysclk_div),
  .o_clock_command_register(o_clock_command_register),
  .o_src_en_ff(o_src_en_ff), .o_sys_src_ff(o_sys_src_ff),
  .o_wd_autoreload_ff(o_wd_autoreload_ff),
  .o_clock_out_pin_ff(o_clock_out_pin_ff),
  .o_clock_out_pin_oe(o_clock_out_pin_oe));
`default_nettype wire
